// *** hdl/ied_arb_if.sv ***
// interface: requests and levels to the arbiter, winner back
`timescale 1ns/1ps
interface ied_arb_if;
    import ied_pkg::*;
    logic [NSRC-1:0]      req;
    logic [NSRC-1:0][1:0] lvl;
    logic                 win_valid;
    logic [3:0]           win_idx;
    logic [1:0]           win_lvl;
    modport ctl (output req, output lvl,
                 input win_valid, input win_idx, input win_lvl);
    modport arb (input req, input lvl,
                 output win_valid, output win_idx, output win_lvl);
endinterface : ied_arb_if

// *** hdl/ied_arbiter.sv ***
// arbiter: highest level wins, lowest source number breaks ties
`timescale 1ns/1ps
module ied_arbiter
    import ied_pkg::*;
(
    ied_arb_if.arb bus
);
    always_comb begin
        bus.win_valid = 1'b0;
        bus.win_idx   = 4'h0;
        bus.win_lvl   = 2'h0;
        // scan downward so an equal level at a lower number replaces
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (bus.req[i] && (!bus.win_valid
                    || bus.lvl[i] >= bus.win_lvl)) begin
                bus.win_valid = 1'b1;
                bus.win_idx   = 4'(i);
                bus.win_lvl   = bus.lvl[i];
            end
        end
    end
endmodule : ied_arbiter

// *** hdl/ied_ctrl.sv ***
// interrupt enable, flag and dispatch controller with apb registers
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - third enable register holds six source enables
// - taken interrupt jumps to its fixed vector
// - only strictly higher level preempts a service
// - return ends service, resumes interrupted code
// - flag sets on condition, enabled or not
// - enabled flag forces long call next cycle
// - blocked request waits until it is highest
// - latency seven machine cycles: detect plus six
// - serial1 receive flag, cleared on vectoring
// - converter done flag, cleared on vectoring
// - serial0 receive flag, cleared on vectoring
// - radio fifo error flag, cleared on vectoring
// - flag bits two and zero reset to one
// - two writable aes flags request service
// - aes request sets both flags together
// - global enable gates every source
// - six groups, each one of four levels
module ied_ctrl
    import ied_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [NSRC-1:0] src_event,
    input  wire logic            core_instr_boundary,
    input  wire logic            core_return_from_irq_instr,
    output logic                 core_force_long_call_instr,
    output logic      [7:0]      core_vector,
    output logic                 core_irq_entry,
    output logic                 core_return_ack,
    output logic                 irq_out
);
    ied_arb_if     arb ();
    ied_state_type state;
    ied_state_type next_state;

    logic [7:0]  timer_ctl_irq_flags;
    logic [7:0]  aes_irq_flags;
    logic [5:0]  irq_enable_third;
    logic [7:0]  irq_ctl;
    logic [5:0]  aux_flags;
    logic [11:0] prio;
    logic [2:0]  evt_status;
    logic [2:0]  evt_mask;
    logic [3:0]  insvc;
    logic [3:0]  act_idx;
    logic [1:0]  act_lvl;
    logic [2:0]  call_cnt;
    logic        tick;

    ied_mcyc_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    ied_arbiter u_arb (
        .bus (arb.arb)
    );

    // apb decode
    logic [7:0]  reg_idx;
    logic        addr_ok;
    logic        hit;
    logic        wr;
    logic        setup;
    logic [31:0] rd_mux;
    logic        wr_tctl;
    logic        wr_aes;
    logic        wr_ien;
    logic        wr_ctl;
    logic        wr_aux;
    logic        wr_prio;
    logic        wr_status;
    logic        wr_mask;

    assign reg_idx  = paddr[9:2];
    assign addr_ok  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign hit      = addr_ok && (reg_idx == IDX_TCTL_FLAGS
                   || reg_idx == IDX_AES_FLAGS || reg_idx == IDX_IEN_THIRD
                   || (reg_idx >= IDX_IRQ_CTL && reg_idx <= IDX_DISPATCH));
    assign setup    = psel && !penable;
    assign wr       = psel && penable && pwrite && hit;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !hit;
    assign wr_tctl  = wr && reg_idx == IDX_TCTL_FLAGS;
    assign wr_aes   = wr && reg_idx == IDX_AES_FLAGS;
    assign wr_ien   = wr && reg_idx == IDX_IEN_THIRD;
    assign wr_ctl   = wr && reg_idx == IDX_IRQ_CTL;
    assign wr_aux   = wr && reg_idx == IDX_AUX_FLAGS;
    assign wr_prio  = wr && reg_idx == IDX_PRIO;
    assign wr_status = wr && reg_idx == IDX_EVT_STATUS;
    assign wr_mask  = wr && reg_idx == IDX_EVT_MASK;

    always_comb begin
        rd_mux = 32'h0;
        if (!addr_ok) begin
            rd_mux = 32'h0;
        end else if (reg_idx == IDX_TCTL_FLAGS) begin
            rd_mux = {24'h0, timer_ctl_irq_flags};
        end else if (reg_idx == IDX_AES_FLAGS) begin
            rd_mux = {24'h0, aes_irq_flags};
        end else if (reg_idx == IDX_IEN_THIRD) begin
            rd_mux = {26'h0, irq_enable_third};
        end else if (reg_idx == IDX_IRQ_CTL) begin
            rd_mux = {24'h0, irq_ctl};
        end else if (reg_idx == IDX_AUX_FLAGS) begin
            rd_mux = {26'h0, aux_flags};
        end else if (reg_idx == IDX_PRIO) begin
            rd_mux = {20'h0, prio};
        end else if (reg_idx == IDX_EVT_STATUS) begin
            rd_mux = {29'h0, evt_status};
        end else if (reg_idx == IDX_EVT_MASK) begin
            rd_mux = {29'h0, evt_mask};
        end else if (reg_idx == IDX_DISPATCH) begin
            rd_mux = {22'h0, state, insvc, act_idx};
        end
    end

    // read data is captured in the setup phase, so no wait state is needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup) begin
            prdata <= rd_mux;
        end
    end

    // per-source pending flag, enable and level
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] src_en;
    logic            global_en;
    logic            entry_go;
    logic [NSRC-1:0] hw_clr;

    assign global_en = irq_ctl[POS_GLOBAL_EN];
    assign pend   = {aux_flags[5], aux_flags[0], aux_flags[4], aux_flags[3],
                     aux_flags[2], aux_flags[1], |aes_irq_flags[1:0],
                     timer_ctl_irq_flags[POS_SER1_RX],
                     timer_ctl_irq_flags[POS_SER0_RX],
                     timer_ctl_irq_flags[POS_CONV_DONE],
                     timer_ctl_irq_flags[POS_RADIO_FIFO]};
    assign src_en = {irq_enable_third[5], irq_enable_third[0],
                     irq_enable_third[4], irq_enable_third[3],
                     irq_enable_third[2], irq_enable_third[1],
                     irq_ctl[4:0]};

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_src
            assign arb.req[g] = pend[g] && src_en[g] && global_en;
            assign arb.lvl[g] = prio[2*SRC_GRP[g] +: 2];
            assign hw_clr[g]  = entry_go && act_idx == 4'(g);
        end
    endgenerate

    // preemption gate against the highest level now in service
    logic [1:0] cur_lvl;
    logic       may_take;
    logic       accept;
    logic       held;

    assign cur_lvl  = insvc[3] ? 2'd3 : insvc[2] ? 2'd2 :
                      insvc[1] ? 2'd1 : 2'd0;
    assign may_take = (insvc == 4'h0) || (arb.win_lvl > cur_lvl);
    assign accept   = tick && state == IED_IDLE && arb.win_valid
                   && may_take && core_instr_boundary;
    assign held     = arb.win_valid && !may_take;
    assign entry_go = tick && state == IED_CALL && call_cnt == CALL_LAST;

    logic [7:0] next_tctl;
    logic [7:0] next_aes;
    logic [5:0] next_aux;
    logic [7:0] tctl_base;

    // flag registers: an event in a clear cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_ctl_irq_flags <= RST_TCTL_FLAGS;
            aes_irq_flags       <= RST_AES_FLAGS;
            aux_flags           <= 6'h00;
        end else begin
            timer_ctl_irq_flags <= next_tctl;
            aes_irq_flags       <= next_aes;
            aux_flags           <= next_aux;
        end
    end

    assign tctl_base = wr_tctl ? pwdata[7:0] : timer_ctl_irq_flags
        & ~{hw_clr[3], 1'b0, hw_clr[1], 1'b0, hw_clr[2], 1'b0,
            hw_clr[0], 1'b0};
    assign next_tctl = tctl_base
        | {src_event[3], 1'b0, src_event[1], 1'b0, src_event[2], 1'b0,
           src_event[0], 1'b0};
    assign next_aes = (wr_aes ? pwdata[7:0] : aes_irq_flags)
        | {6'h00, {2{src_event[4]}}};
    assign next_aux = (wr_aux ? pwdata[5:0] : aux_flags)
        | {src_event[10], src_event[8], src_event[7], src_event[6],
           src_event[5], src_event[9]};

    // software controlled registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_third <= RST_IEN_THIRD;
            irq_ctl          <= RST_IRQ_CTL;
            prio             <= RST_PRIO;
            evt_mask         <= 3'h0;
        end else begin
            if (wr_ien) irq_enable_third <= pwdata[5:0];
            if (wr_ctl) irq_ctl <= pwdata[7:0] & 8'h9f;
            if (wr_prio) prio <= pwdata[11:0];
            if (wr_mask) evt_mask <= pwdata[2:0];
        end
    end

    // dispatch sequence, one step per machine cycle
    always_comb begin
        next_state = state;
        case (state)
            IED_IDLE: begin
                if (accept) next_state = IED_DETECT;
            end
            IED_DETECT: begin
                if (tick) next_state = IED_CALL;
            end
            IED_CALL: begin
                if (entry_go) next_state = IED_IDLE;
            end
            default: begin
                next_state = IED_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= IED_IDLE;
            call_cnt <= 3'h0;
            act_idx  <= 4'h0;
            act_lvl  <= 2'h0;
        end else begin
            state <= next_state;
            if (accept) begin
                act_idx <= arb.win_idx;
                act_lvl <= arb.win_lvl;
            end
            if (state != IED_CALL) call_cnt <= 3'h0;
            else if (tick) call_cnt <= call_cnt + 3'h1;
        end
    end

    // in-service levels; return drops the highest one
    logic [3:0] top_bit;
    assign top_bit = insvc[3] ? 4'h8 : insvc[2] ? 4'h4 :
                     insvc[1] ? 4'h2 : insvc[0] ? 4'h1 : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insvc           <= 4'h0;
            core_vector     <= 8'h00;
            core_irq_entry  <= 1'b0;
            core_return_ack <= 1'b0;
        end else begin
            core_irq_entry  <= entry_go;
            core_return_ack <= core_return_from_irq_instr && insvc != 4'h0;
            if (entry_go) insvc <= insvc | (4'h1 << act_lvl);
            else if (core_return_from_irq_instr) insvc <= insvc & ~top_bit;
            if (accept) begin
                core_vector <= VEC_BASE
                    + {SRC_NUM[arb.win_idx], 3'b000};
            end
        end
    end

    assign core_force_long_call_instr = (state == IED_CALL);

    // block events: sticky, write one to clear, set wins
    logic [2:0] evt_set;
    assign evt_set = {held, core_return_from_irq_instr && insvc != 4'h0, entry_go};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= 3'h0;
            irq_out    <= 1'b0;
        end else begin
            evt_status <= (evt_status & ~(wr_status ? pwdata[2:0] : 3'h0))
                        | evt_set;
            irq_out    <= |(evt_status & evt_mask);
        end
    end

    sequence s_call_start;
        $rose(core_force_long_call_instr);
    endsequence

    // first eight clocks of the call; the rest counted by the delays
    sequence s_call_hold;
        core_force_long_call_instr [*8];
    endsequence

    sequence s_call_done;
        core_irq_entry && !core_force_long_call_instr;
    endsequence

    a_call_latency: assert property (@(posedge pclk) disable iff (!presetn)
        s_call_start |-> s_call_hold ##16 core_force_long_call_instr
            ##1 s_call_done)
        else $error("long call did not last six machine cycles");
    a_detect_first: assert property (@(posedge pclk) disable iff (!presetn)
        s_call_start |-> $past(state) == IED_DETECT)
        else $error("long call began without a detect cycle");
    a_vector_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        core_irq_entry |-> core_vector
            == VEC_BASE + {SRC_NUM[act_idx], 3'b000})
        else $error("vector does not match taken source");
    a_no_low_preempt: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == IED_DETECT) && $past(insvc) != 4'h0
            |-> act_lvl > $past(cur_lvl))
        else $error("service preempted by lower or equal level");
    a_gate_global: assert property (@(posedge pclk) disable iff (!presetn)
        state == IED_IDLE && !global_en |=> state == IED_IDLE)
        else $error("interrupt taken with global enable clear");
    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        src_event[3] |=> timer_ctl_irq_flags[POS_SER1_RX])
        else $error("serial1 receive flag not set");
    a_flag_vector_clr: assert property (@(posedge pclk) disable iff (!presetn)
        core_irq_entry && act_idx == 4'h1 && !$past(src_event[1])
            && !$past(wr_tctl)
            |-> !timer_ctl_irq_flags[POS_CONV_DONE])
        else $error("converter flag not cleared on vectoring");
    a_aes_both_set: assert property (@(posedge pclk) disable iff (!presetn)
        src_event[4] |=> aes_irq_flags[1:0] == 2'b11)
        else $error("aes request did not set both flags");
    a_ien_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        setup && addr_ok && reg_idx == IDX_IEN_THIRD
            |=> prdata[7:6] == 2'b00)
        else $error("unused enable bits read nonzero");
    a_return_drops: assert property (@(posedge pclk) disable iff (!presetn)
        core_return_from_irq_instr && !entry_go && insvc != 4'h0
            |=> $countones(insvc) == $countones($past(insvc)) - 1)
        else $error("return did not end one service level");
endmodule : ied_ctrl

// *** hdl/ied_mcyc_div.sv ***
// machine cycle divider: one-cycle tick every MCYC_CLKS clocks
`timescale 1ns/1ps
module ied_mcyc_div
    import ied_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    logic [3:0] count;
    logic       wrap;

    assign wrap = (count == 4'(MCYC_CLKS - 1));
    assign tick = wrap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
        end else begin
            count <= wrap ? 4'h0 : count + 4'h1;
        end
    end

    a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick [*3] ##1 tick)
        else $error("machine cycle tick period wrong");
endmodule : ied_mcyc_div

// *** hdl/ied_pkg.sv ***
// package: register map, field positions, resets and timing of the block
package ied_pkg;
    localparam int NSRC = 11;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_TCTL_FLAGS = 8'h88;
    localparam logic [7:0] IDX_AES_FLAGS  = 8'h98;
    localparam logic [7:0] IDX_IEN_THIRD  = 8'h9a;
    localparam logic [7:0] IDX_IRQ_CTL    = 8'ha0;
    localparam logic [7:0] IDX_AUX_FLAGS  = 8'ha1;
    localparam logic [7:0] IDX_PRIO       = 8'ha2;
    localparam logic [7:0] IDX_EVT_STATUS = 8'ha3;
    localparam logic [7:0] IDX_EVT_MASK   = 8'ha4;
    localparam logic [7:0] IDX_DISPATCH   = 8'ha5;
    // reset values
    localparam logic [7:0]  RST_TCTL_FLAGS = 8'h05;
    localparam logic [7:0]  RST_AES_FLAGS  = 8'h00;
    localparam logic [5:0]  RST_IEN_THIRD  = 6'h00;
    localparam logic [7:0]  RST_IRQ_CTL    = 8'h00;
    localparam logic [11:0] RST_PRIO       = 12'h000;
    // field positions
    localparam int POS_GLOBAL_EN   = 7;
    localparam int POS_SER1_RX     = 7;
    localparam int POS_CONV_DONE   = 5;
    localparam int POS_SER0_RX     = 3;
    localparam int POS_RADIO_FIFO  = 1;
    localparam int POS_EVT_TAKEN   = 0;
    localparam int POS_EVT_RETURN  = 1;
    localparam int POS_EVT_HELD    = 2;
    // source index: 0 radio fifo err, 1 converter, 2 serial0 rx,
    // 3 serial1 rx, 4 aes, 5 port two, 6 serial0 tx, 7 serial1 tx,
    // 8 port one, 9 radio general, 10 watchdog
    localparam logic [NSRC-1:0][4:0] SRC_NUM = {
        5'h11, 5'h10, 5'h0f, 5'h0e, 5'h07, 5'h06,
        5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
    localparam logic [NSRC-1:0][2:0] SRC_GRP = {
        3'h5, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1,
        3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    localparam logic [7:0] VEC_BASE = 8'h03;
    // timing: one machine cycle is MCYC_CLKS clocks
    localparam int MCYC_CLKS   = 4;
    localparam int DETECT_MCYC = 1;
    localparam int CALL_MCYC   = 6;
    localparam logic [2:0] CALL_LAST = 3'(CALL_MCYC - 1);

    typedef enum logic [1:0] {
        IED_IDLE   = 2'b00,
        IED_DETECT = 2'b01,
        IED_CALL   = 2'b11
    } ied_state_type;
endpackage : ied_pkg

// *** sim/ied_cpu_model.sv ***
// cpu core model: instruction boundaries and return pulses
`timescale 1ns/1ps
module ied_cpu_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow,
    input  wire logic ret_req,
    output logic      core_instr_boundary,
    output logic      core_return_from_irq_instr
);
    logic [2:0] cnt;
    // slow core: one boundary in five clocks, walks across all tick phases
    assign core_instr_boundary = !slow || (cnt == 3'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= 3'h0;
            core_return_from_irq_instr <= 1'b0;
        end else begin
            cnt       <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
            core_return_from_irq_instr <= ret_req && !core_return_from_irq_instr;
        end
    end
endmodule : ied_cpu_model

// *** sim/ied_tb_top.sv ***
// testbench: register access, flags, dispatch, nesting, interrupt out
`timescale 1ns/1ps
module ied_tb_top
    import ied_pkg::*;
();
    typedef struct {
        logic [7:0]      idx;
        logic [NSRC-1:0] src;
        logic [31:0]     wd;
        logic [31:0]     exp;
    } ied_row_type;
    logic            pclk, presetn, psel, penable, pwrite, slow, ret_req;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic            pready, pslverr, err, lc_q;
    logic            core_instr_boundary, core_return_from_irq_instr, core_force_long_call_instr;
    logic            core_irq_entry, core_return_ack, irq_out;
    logic [7:0]      core_vector;
    logic [NSRC-1:0] src_event;
    int              miscompares, n_tests, lcalls;
    // plain rows write then read; event rows pulse, read, then clear
    ied_row_type rows [18] = '{
        '{IDX_IEN_THIRD, 11'h000, 32'hff, 32'h3f},
        '{IDX_IEN_THIRD, 11'h000, 32'h15, 32'h15},
        '{IDX_AES_FLAGS, 11'h000, 32'h01, 32'h01},
        '{IDX_AES_FLAGS, 11'h000, 32'h02, 32'h02},
        '{IDX_AES_FLAGS, 11'h000, 32'h00, 32'h00},
        '{IDX_TCTL_FLAGS, 11'h000, 32'haf, 32'haf},
        '{IDX_TCTL_FLAGS, 11'h000, 32'h05, 32'h05},
        '{IDX_TCTL_FLAGS, 11'h001, 32'h05, 32'h07},
        '{IDX_TCTL_FLAGS, 11'h002, 32'h05, 32'h25},
        '{IDX_TCTL_FLAGS, 11'h004, 32'h05, 32'h0d},
        '{IDX_TCTL_FLAGS, 11'h008, 32'h05, 32'h85},
        '{IDX_AES_FLAGS, 11'h010, 32'h00, 32'h03},
        '{IDX_AUX_FLAGS, 11'h020, 32'h00, 32'h02},
        '{IDX_AUX_FLAGS, 11'h040, 32'h00, 32'h04},
        '{IDX_AUX_FLAGS, 11'h080, 32'h00, 32'h08},
        '{IDX_AUX_FLAGS, 11'h100, 32'h00, 32'h10},
        '{IDX_AUX_FLAGS, 11'h200, 32'h00, 32'h01},
        '{IDX_AUX_FLAGS, 11'h400, 32'h00, 32'h20}};

    ied_ctrl i_ied_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_event(src_event),
        .core_instr_boundary(core_instr_boundary), .core_return_from_irq_instr(core_return_from_irq_instr),
        .core_force_long_call_instr(core_force_long_call_instr), .core_vector(core_vector),
        .core_irq_entry(core_irq_entry),
        .core_return_ack(core_return_ack), .irq_out(irq_out));
    ied_cpu_model i_ied_cpu_model (
        .pclk(pclk), .presetn(presetn), .slow(slow), .ret_req(ret_req),
        .core_instr_boundary(core_instr_boundary), .core_return_from_irq_instr(core_return_from_irq_instr));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        lc_q <= core_force_long_call_instr;
        if (core_force_long_call_instr === 1'b1 && lc_q !== 1'b1) lcalls++;
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic tmo;
        miscompares++;
        results();
    endtask : tmo
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one apb transfer; starts one edge later so psel never toggles twice
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask : rdchk
    task automatic fire(input logic [NSRC-1:0] m);
        @(posedge pclk);
        src_event <= m;
        @(posedge pclk);
        src_event <= '0;
    endtask : fire
    // waits for the forced call, checks vector, length and entry pulse
    task automatic take(input logic [7:0] vec);
        int k;
        k = 0;
        while (core_force_long_call_instr !== 1'b1) begin
            @(posedge pclk);
            if (++k > 300) tmo();
        end
        check(32'(core_vector), 32'(vec));
        k = 0;
        while (core_force_long_call_instr === 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        check(32'(k), 32'(CALL_MCYC * MCYC_CLKS));
        check(32'(core_irq_entry), 32'h1);
    endtask : take
    task automatic return_from_irq_instr;
        int k;
        @(posedge pclk);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
        k = 0;
        while (core_return_ack !== 1'b1) begin
            @(posedge pclk);
            if (++k > 20) tmo();
        end
    endtask : return_from_irq_instr

    initial begin
        {presetn, psel, penable, pwrite, slow, ret_req} = '0;
        paddr = '0;
        pwdata = '0;
        src_event = '0;
        {miscompares, n_tests} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(IDX_TCTL_FLAGS, 32'h05);
        rdchk(IDX_AES_FLAGS, 32'(RST_AES_FLAGS));
        rdchk(IDX_IEN_THIRD, 32'h00);
        foreach (rows[i]) begin
            if (rows[i].src != '0) fire(rows[i].src);
            else apb(1'b1, rows[i].idx, rows[i].wd);
            rdchk(rows[i].idx, rows[i].exp);
            if (rows[i].src != '0) apb(1'b1, rows[i].idx, rows[i].wd);
        end
        check(32'(lcalls), 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // nesting: serial1 rx in service, converter waits at equal level
        apb(1'b1, IDX_EVT_MASK, 32'h07);
        apb(1'b1, IDX_IRQ_CTL, 32'h8a);
        fire(11'h008);
        take(8'h1b);
        rdchk(IDX_TCTL_FLAGS, 32'h05);
        rdchk(IDX_DISPATCH, 32'h13);
        check(32'(irq_out), 32'h1);
        fire(11'h002);
        repeat (60) @(posedge pclk);
        check(32'(lcalls), 32'h1);
        rdchk(IDX_EVT_STATUS, 32'h05);
        apb(1'b1, IDX_EVT_MASK, 32'h00);
        rdchk(IDX_EVT_MASK, 32'h00);
        check(32'(irq_out), 32'h0);
        apb(1'b1, IDX_PRIO, 32'h004);
        take(8'h0b);
        rdchk(IDX_TCTL_FLAGS, 32'h05);
        return_from_irq_instr();
        return_from_irq_instr();
        rdchk(IDX_EVT_STATUS, 32'h07);
        // equal levels together on a slow core: lowest number first
        apb(1'b1, IDX_PRIO, 32'h000);
        apb(1'b1, IDX_IRQ_CTL, 32'h85);
        slow <= 1'b1;
        fire(11'h005);
        take(8'h03);
        rdchk(IDX_TCTL_FLAGS, 32'h0d);
        return_from_irq_instr();
        take(8'h13);
        rdchk(IDX_TCTL_FLAGS, 32'h05);
        return_from_irq_instr();
        slow <= 1'b0;
        // one software-set aes flag alone requests service
        apb(1'b1, IDX_IRQ_CTL, 32'h90);
        apb(1'b1, IDX_AES_FLAGS, 32'h02);
        take(8'h23);
        apb(1'b1, IDX_AES_FLAGS, 32'h00);
        return_from_irq_instr();
        apb(1'b1, IDX_EVT_STATUS, 32'h07);
        apb(1'b1, IDX_EVT_MASK, 32'h07);
        rdchk(IDX_EVT_STATUS, 32'h00);
        check(32'(irq_out), 32'h0);
        // mid-run reset: dirty flags, enables and vector go back
        apb(1'b1, IDX_TCTL_FLAGS, 32'haf);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check(32'(core_vector), 32'h0);
        presetn <= 1'b1;
        rdchk(IDX_TCTL_FLAGS, 32'h05);
        rdchk(IDX_IEN_THIRD, 32'h00);
        rdchk(IDX_IRQ_CTL, 32'h00);
        results();
    end
endmodule : ied_tb_top
